// File: hw/otp_seq_defines.svh
// Constants for the manual command sequencer that drives the one-time programmable memory.
`ifndef OTP_SEQ_DEFINES_SVH
`define OTP_SEQ_DEFINES_SVH
`define OFS_TIMING     4'h0
`define OFS_COMMAND    4'h1
`define OFS_CONTROL    4'h2
`define OFS_ADDR       4'h3
`define OFS_WDATA      4'h4
`define OFS_START      4'h5
`define OFS_ACCESS     4'h6
`define OFS_DATA_SEL   4'h7
`define OFS_EVENT      4'h8
`define OFS_STARTUP    4'h9
`define RST_TIMING     32'h0001_8070
`define RST_CONTROL    8'h08
`define RST_DATA_SEL   8'hf0
`define UNLOCK_VALUE   8'h97
`define READY_BIT      7
`define CMD_NOP        4'h0
`define CMD_RESET      4'h1
`define CMD_POWER_UP   4'h4
`define CMD_POWER_DOWN 4'h5
`define CMD_READ       4'h6
`define CMD_WRITE      4'h7
`define CMD_PROGRAM    4'h8
`define CMD_WAIT       4'hd
`define CMD_PGM_ASSIST 4'he
`endif

// File: hw/otp_seq_pkg.sv
// Types shared by the manual command sequencer.
package otp_seq_pkg;
  typedef struct packed {
    logic [17:0] pulse;
    logic [9:0]  recovery;
    logic [1:0]  hold;
    logic [1:0]  setup;
  } timing_t;

  typedef struct packed {
    logic        enable;
    logic        aux_b;
    logic        aux_a;
    logic        mode_sel;
    logic        all_bank;
    logic [3:0]  op;
    logic        strobe;
    logic [10:0] addr;
    logic [31:0] data;
  } macro_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD,
    ST_RECOVERY
  } stage_t;
endpackage

// File: hw/otp_manual_command_sequencer.sv
// Register-driven sequencer that steps manual commands into the OTP memory macro.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "otp_seq_defines.svh"

module otp_manual_command_sequencer #(
  parameter int ADDR_W = 11,
  parameter int PASSES = 2
) (
  // Clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_resetn,
  // Register port
  input  wire logic [3:0]               i_reg_addr,
  input  wire logic [31:0]              i_reg_wdata,
  input  wire logic                     i_reg_write,
  input  wire logic                     i_reg_read,
  output logic      [31:0]              o_reg_rdata,
  // Start-up sequence request from the controller
  input  wire logic                     i_startup_read,
  // Macro side
  output otp_seq_pkg::macro_cmd_t       o_macro,
  output logic                          o_busy
);
  import otp_seq_pkg::*;

  // The address register and the pass counter are sized for these values only.
  if (ADDR_W != 11) begin : g_bad_addr_w
    $error("ADDR_W must be 11");
  end
  if (PASSES < 1 || PASSES > 3) begin : g_bad_passes
    $error("PASSES must be 1 to 3");
  end

  timing_t     timing_q;
  logic [7:0]  command_q;
  logic [7:0]  control_q;
  logic [10:0] addr_q;
  logic [31:0] wdata_q;
  logic [7:0]  access_q;
  logic [7:0]  data_sel_q;
  logic        ready_q;
  logic        assist_mode_q;
  stage_t      stage_q;
  logic [17:0] count_q;
  logic [3:0]  mask_q;
  logic [3:0]  op_q;
  logic        assist_q;
  logic [1:0]  pass_q;
  logic        done;
  logic        start_ok;
  logic [31:0] rdata_d;

  wire wr = i_reg_write;
  wire unlocked = (access_q == `UNLOCK_VALUE);
  assign start_ok = wr && i_reg_addr == `OFS_START && i_reg_wdata[0] && unlocked
                    && stage_q == ST_IDLE;

  // Decodes a command code into the operation driven into the macro.
  function automatic logic [3:0] macro_op(input logic [3:0] code);
    case (code)
      `CMD_RESET, `CMD_POWER_UP, `CMD_POWER_DOWN, `CMD_READ,
      `CMD_WRITE, `CMD_PROGRAM: macro_op = code;
      default:                  macro_op = `CMD_NOP;
    endcase
  endfunction

  // Picks the first enabled stage at or after a position in the fixed order.
  function automatic stage_t next_stage(input logic [3:0] mask, input logic [2:0] from,
                                        input logic skip_hold);
    next_stage = ST_IDLE;
    if (from <= 3'd1 && mask[3]) next_stage = ST_SETUP;
    else if (from <= 3'd2 && mask[2]) next_stage = ST_PULSE;
    else if (from <= 3'd3 && mask[1] && !skip_hold) next_stage = ST_HOLD;
    else if (from <= 3'd4 && mask[0]) next_stage = ST_RECOVERY;
  endfunction

  // Stage length minus one; the count register runs down to zero.
  function automatic logic [17:0] stage_len(input stage_t s, input timing_t t);
    case (s)
      ST_SETUP:    stage_len = {16'h0000, t.setup};
      ST_PULSE:    stage_len = t.pulse;
      ST_HOLD:     stage_len = {16'h0000, t.hold};
      ST_RECOVERY: stage_len = {8'h00, t.recovery};
      default:     stage_len = 18'h0_0000;
    endcase
  endfunction

  // Register writes.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      timing_q   <= timing_t'(`RST_TIMING);
      command_q  <= 8'h00;
      control_q  <= `RST_CONTROL;
      addr_q     <= 11'h000;
      wdata_q    <= 32'h0000_0000;
      access_q   <= 8'h00;
      data_sel_q <= `RST_DATA_SEL;
      assist_mode_q <= 1'b0;
    end else if (wr) begin
      case (i_reg_addr)
        `OFS_TIMING:   timing_q <= i_reg_wdata;
        `OFS_COMMAND:  command_q <= i_reg_wdata[7:0];
        `OFS_CONTROL:  control_q <= {i_reg_wdata[7:3], 3'h0};
        `OFS_ADDR:     addr_q <= i_reg_wdata[10:0];
        `OFS_WDATA:    wdata_q <= i_reg_wdata;
        `OFS_ACCESS:   access_q <= i_reg_wdata[7:0];
        `OFS_DATA_SEL: data_sel_q <= {i_reg_wdata[7:4], 1'b0, i_reg_wdata[2:0]};
        `OFS_STARTUP:  assist_mode_q <= i_reg_wdata[0];
        default: ;
      endcase
    end
  end

  // Stage sequencer.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stage_q  <= ST_IDLE;
      count_q  <= 18'h0_0000;
      mask_q   <= 4'h0;
      op_q     <= `CMD_NOP;
      assist_q <= 1'b0;
      pass_q   <= 2'h0;
    end else if (start_ok) begin
      mask_q   <= command_q[7:4];
      op_q     <= command_q[3:0];
      assist_q <= command_q[3:0] == `CMD_PGM_ASSIST;
      pass_q   <= 2'h0;
      stage_q  <= next_stage(command_q[7:4], 3'd0, command_q[3:0] == `CMD_PGM_ASSIST);
      count_q  <= stage_len(next_stage(command_q[7:4], 3'd0,
                            command_q[3:0] == `CMD_PGM_ASSIST), timing_q);
    end else if (stage_q != ST_IDLE) begin
      if (count_q != 18'h0_0000) begin
        count_q <= count_q - 18'h0_0001;
      end else if (next_stage(mask_q, 3'(stage_q) + 3'd1, assist_q) != ST_IDLE) begin
        stage_q <= next_stage(mask_q, 3'(stage_q) + 3'd1, assist_q);
        count_q <= stage_len(next_stage(mask_q, 3'(stage_q) + 3'd1, assist_q), timing_q);
      end else if (assist_q && pass_q != 2'(PASSES - 1)) begin
        // Assist repeats read, program and verify passes through the same stages.
        pass_q  <= pass_q + 2'h1;
        stage_q <= next_stage(mask_q, 3'd0, 1'b1);
        count_q <= stage_len(next_stage(mask_q, 3'd0, 1'b1), timing_q);
      end else begin
        stage_q <= ST_IDLE;
      end
    end
  end

  assign done = stage_q != ST_IDLE && count_q == 18'h0_0000
                && next_stage(mask_q, 3'(stage_q) + 3'd1, assist_q) == ST_IDLE
                && !(assist_q && pass_q != 2'(PASSES - 1));

  // Manual-ready flag; a completion in the clearing cycle wins.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ready_q <= 1'b0;
    end else if (done) begin
      ready_q <= 1'b1;
    end else if (wr && i_reg_addr == `OFS_EVENT && i_reg_wdata[`READY_BIT]) begin
      ready_q <= 1'b0;
    end
  end

  // Macro drive, registered so the pins never glitch.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_macro <= '0;
    end else begin
      o_macro.enable   <= control_q[7] | i_startup_read;
      o_macro.aux_b    <= control_q[6];
      o_macro.aux_a    <= control_q[5];
      o_macro.mode_sel <= control_q[4];
      o_macro.all_bank <= control_q[3];
      o_macro.op       <= stage_q == ST_IDLE ? `CMD_NOP
                          : (assist_q ? (pass_q == 2'h1 ? `CMD_PROGRAM : `CMD_READ)
                                      : macro_op(op_q));
      o_macro.strobe   <= stage_q == ST_PULSE && (assist_q || macro_op(op_q) != `CMD_NOP);
      o_macro.addr     <= (assist_q && !assist_mode_q) ? {addr_q[10:1], 1'b0} : addr_q;
      if (assist_q) begin
        for (int b = 0; b < 4; b++) begin
          // Disabled bytes carry the unprogrammed value so no fuse is blown.
          o_macro.data[8*b +: 8] <= data_sel_q[4+b] ? wdata_q[8*b +: 8] : 8'h00;
        end
      end else if (op_q == `CMD_WRITE && (control_q[4] || control_q[5] || control_q[6])) begin
        o_macro.data <= {16'h0000, wdata_q[15:0]};
      end else begin
        o_macro.data <= wdata_q;
      end
    end
  end
  assign o_busy = stage_q != ST_IDLE;

  // Register read mux; the start register always reads back zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (i_reg_addr)
      `OFS_TIMING:   rdata_d = timing_q;
      `OFS_COMMAND:  rdata_d = {24'h00_0000, command_q};
      `OFS_CONTROL:  rdata_d = {24'h00_0000, control_q};
      `OFS_ADDR:     rdata_d = {21'h00_0000, addr_q};
      `OFS_WDATA:    rdata_d = wdata_q;
      `OFS_START:    rdata_d = 32'h0000_0000;
      `OFS_ACCESS:   rdata_d = {24'h00_0000, access_q};
      `OFS_DATA_SEL: rdata_d = {24'h00_0000, data_sel_q};
      `OFS_EVENT:    rdata_d = {24'h00_0000, ready_q, 7'h00};
      `OFS_STARTUP:  rdata_d = {28'h000_0000, 2'(stage_q), o_busy, assist_mode_q};
      default:       rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_read) begin
      o_reg_rdata <= rdata_d;
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

  // Checks.
  property p_pulse_len;
    @(posedge i_clock) disable iff (!i_resetn)
    $rose(stage_q == ST_PULSE) |-> count_q == timing_q.pulse;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse count bad");

  property p_rec_len;
    @(posedge i_clock) disable iff (!i_resetn)
    (stage_q != ST_RECOVERY ##1 stage_q == ST_RECOVERY) |-> count_q == {8'h00, timing_q.recovery};
  endproperty
  a_rec_len: assert property (p_rec_len) else $error("recovery count bad");

  property p_no_hold_assist;
    @(posedge i_clock) disable iff (!i_resetn)
    assist_q |-> stage_q != ST_HOLD;
  endproperty
  a_no_hold_assist: assert property (p_no_hold_assist) else $error("hold in assist");

  property p_setup_len;
    @(posedge i_clock) disable iff (!i_resetn)
    start_ok && command_q[7] |=> stage_q == ST_SETUP && count_q == {16'h0000, timing_q.setup};
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup start bad");

  property p_wait_silent;
    @(posedge i_clock) disable iff (!i_resetn)
    (o_busy && op_q == `CMD_WAIT) |=> o_macro.op == `CMD_NOP && !o_macro.strobe;
  endproperty
  a_wait_silent: assert property (p_wait_silent) else $error("wait drove macro");

  property p_locked;
    @(posedge i_clock) disable iff (!i_resetn)
    (!o_busy && !unlocked) |=> !o_busy;
  endproperty
  a_locked: assert property (p_locked) else $error("ran while protected");

  property p_ready;
    @(posedge i_clock) disable iff (!i_resetn)
    done |=> ready_q;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not set");

  property p_aux;
    @(posedge i_clock) disable iff (!i_resetn)
    ##1 (o_macro.aux_b == $past(control_q[6]) && o_macro.aux_a == $past(control_q[5])
         && o_macro.mode_sel == $past(control_q[4]));
  endproperty
  a_aux: assert property (p_aux) else $error("select pins wrong");

  property p_start_read;
    @(posedge i_clock) disable iff (!i_resetn)
    i_reg_read && i_reg_addr == `OFS_START |=> o_reg_rdata == 32'h0000_0000;
  endproperty
  a_start_read: assert property (p_start_read) else $error("start read nonzero");

  property p_hold_len;
    @(posedge i_clock) disable iff (!i_resetn)
    $rose(stage_q == ST_HOLD) |-> count_q == {16'h0000, timing_q.hold};
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold count bad");

  property p_strobe;
    @(posedge i_clock) disable iff (!i_resetn)
    o_macro.strobe |-> $past(stage_q == ST_PULSE);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe outside pulse");

  // A stage may only be visited when its mask bit is set.
  property p_mask;
    @(posedge i_clock) disable iff (!i_resetn)
    o_busy |-> (stage_q != ST_SETUP || mask_q[3]) && (stage_q != ST_PULSE || mask_q[2])
               && (stage_q != ST_HOLD || mask_q[1]) && (stage_q != ST_RECOVERY || mask_q[0]);
  endproperty
  a_mask: assert property (p_mask) else $error("masked stage entered");

  property p_hold_next;
    @(posedge i_clock) disable iff (!i_resetn)
    stage_q == ST_HOLD |=> stage_q inside {ST_HOLD, ST_RECOVERY, ST_IDLE};
  endproperty
  a_hold_next: assert property (p_hold_next) else $error("stage order after hold");

  property p_rec_next;
    @(posedge i_clock) disable iff (!i_resetn)
    (stage_q == ST_RECOVERY && !assist_q) |=> stage_q inside {ST_RECOVERY, ST_IDLE};
  endproperty
  a_rec_next: assert property (p_rec_next) else $error("stage order after recovery");

  property p_op_decode;
    @(posedge i_clock) disable iff (!i_resetn)
    (o_busy && !assist_q && op_q inside {`CMD_RESET, `CMD_POWER_UP, `CMD_POWER_DOWN,
                                         `CMD_READ, `CMD_WRITE, `CMD_PROGRAM})
      |=> o_macro.op == $past(op_q);
  endproperty
  a_op_decode: assert property (p_op_decode) else $error("operation code wrong");

  property p_assist_op;
    @(posedge i_clock) disable iff (!i_resetn)
    (o_busy && assist_q) |=> o_macro.op inside {`CMD_PROGRAM, `CMD_READ};
  endproperty
  a_assist_op: assert property (p_assist_op) else $error("assist operation wrong");

  property p_enable_on;
    @(posedge i_clock) disable iff (!i_resetn)
    i_startup_read |=> o_macro.enable;
  endproperty
  a_enable_on: assert property (p_enable_on) else $error("start-up enable missing");

  property p_enable_off;
    @(posedge i_clock) disable iff (!i_resetn)
    (!i_startup_read && !control_q[7]) |=> !o_macro.enable;
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("enable left on");

  property p_all_bank;
    @(posedge i_clock) disable iff (!i_resetn)
    1'b1 |=> o_macro.all_bank == $past(control_q[3]);
  endproperty
  a_all_bank: assert property (p_all_bank) else $error("all-bank pin wrong");

  property p_diff_addr;
    @(posedge i_clock) disable iff (!i_resetn)
    (o_busy && assist_q && !assist_mode_q) |=> !o_macro.addr[0];
  endproperty
  a_diff_addr: assert property (p_diff_addr) else $error("odd address in assist");

  property p_assist_data;
    @(posedge i_clock) disable iff (!i_resetn)
    (o_busy && assist_q && data_sel_q[7]) |=> o_macro.data[31:24] == $past(wdata_q[31:24]);
  endproperty
  a_assist_data: assert property (p_assist_data) else $error("assist data inverted");

  // In assist passes a disabled byte 0 must never reach the macro as programmable data.
  property p_byte_gate;
    @(posedge i_clock) disable iff (!i_resetn)
    (o_busy && assist_q && !data_sel_q[4]) |=> o_macro.data[7:0] == 8'h00;
  endproperty
  a_byte_gate: assert property (p_byte_gate) else $error("disabled byte driven");

  property p_mr_data;
    @(posedge i_clock) disable iff (!i_resetn)
    (o_busy && !assist_q && op_q == `CMD_WRITE && control_q[4])
      |=> o_macro.data == {16'h0000, $past(wdata_q[15:0])};
  endproperty
  a_mr_data: assert property (p_mr_data) else $error("mode register data wrong");

  property p_plain_data;
    @(posedge i_clock) disable iff (!i_resetn)
    (o_busy && !assist_q && op_q == `CMD_WRITE && control_q[6:4] == 3'h0)
      |=> o_macro.data == $past(wdata_q);
  endproperty
  a_plain_data: assert property (p_plain_data) else $error("data register write wrong");

  property p_start_busy;
    @(posedge i_clock) disable iff (!i_resetn)
    start_ok |=> o_busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start ignored");

  property p_clear;
    @(posedge i_clock) disable iff (!i_resetn)
    (!done && wr && i_reg_addr == `OFS_EVENT && i_reg_wdata[`READY_BIT]) |=> !ready_q;
  endproperty
  a_clear: assert property (p_clear) else $error("ready not cleared");

  c_run: cover property (@(posedge i_clock) disable iff (!i_resetn) start_ok ##[1:200] done);
  c_assist: cover property (@(posedge i_clock) disable iff (!i_resetn) assist_q && done);
  c_clear: cover property (@(posedge i_clock) disable iff (!i_resetn) $fell(ready_q));
  c_wait: cover property (@(posedge i_clock) disable iff (!i_resetn) done && op_q == `CMD_WAIT);
endmodule

// File: dv/otp_macro_model.sv
// Passive model of the programmable memory macro that records what each pulse carried.
`timescale 1ns/100ps
module otp_macro_model (
  // Clock
  input  wire logic                    i_clock,
  // Command bundle from the sequencer
  input  wire otp_seq_pkg::macro_cmd_t i_macro,
  // What the macro saw during its last pulse, plus a running count of strobed cycles with a non-zero operation
  output logic      [15:0]             o_pulse_len,
  output logic      [15:0]             o_active,
  output logic      [3:0]              o_op,
  output logic      [4:0]              o_ctl,
  output logic      [10:0]             o_addr,
  output logic      [10:0]             o_prog_addr,
  output logic      [31:0]             o_prog_data
);
  import otp_seq_pkg::*;
  logic strobe_q;

  initial begin
    strobe_q    = 1'b0;
    o_pulse_len = 16'h0;
    o_active    = 16'h0;
  end

  // Every strobed cycle is recorded; only one whose operation code is not a no-operation counts as active.
  always @(posedge i_clock) begin
    strobe_q <= i_macro.strobe;
    if (i_macro.strobe) begin
      o_pulse_len <= strobe_q ? o_pulse_len + 16'h1 : 16'h1;
      o_op        <= i_macro.op;
      o_ctl       <= {i_macro.enable, i_macro.aux_b, i_macro.aux_a, i_macro.mode_sel,
                      i_macro.all_bank};
      o_addr      <= i_macro.addr;
      if (i_macro.op != 4'h0) begin
        o_active <= o_active + 16'h1;
      end
      if (i_macro.op == 4'h8 && !strobe_q) begin
        o_prog_addr <= i_macro.addr;
        o_prog_data <= i_macro.data;
      end
    end
  end
endmodule

// File: dv/otp_manual_command_sequencer_tb_top.sv
// Self-checking bench for the manual command sequencer and its macro model.
`timescale 1ns/100ps
module otp_manual_command_sequencer_tb_top;
  import otp_seq_pkg::*;
  logic        i_clock;
  logic        i_resetn;
  logic [3:0]  i_reg_addr;
  logic [31:0] i_reg_wdata;
  logic        i_reg_write;
  logic        i_reg_read;
  logic [31:0] o_reg_rdata;
  logic        i_startup_read;
  macro_cmd_t  o_macro;
  logic        o_busy;
  logic [15:0] pulse_len;
  logic [15:0] active;
  logic [3:0]  op_seen;
  logic [4:0]  ctl_seen;
  logic [10:0] addr_seen;
  logic [10:0] prog_addr;
  logic [31:0] prog_data;
  logic [31:0] rv;
  int          n_fail;
  int          checks_done;

  otp_manual_command_sequencer #(.ADDR_W(11), .PASSES(2)) otp_manual_command_sequencer_i (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
    .o_reg_rdata(o_reg_rdata), .i_startup_read(i_startup_read), .o_macro(o_macro),
    .o_busy(o_busy));

  otp_macro_model otp_macro_model_i (
    .i_clock(i_clock), .i_macro(o_macro), .o_pulse_len(pulse_len), .o_active(active),
    .o_op(op_seen), .o_ctl(ctl_seen), .o_addr(addr_seen), .o_prog_addr(prog_addr),
    .o_prog_data(prog_data));

  always #50 i_clock = ~i_clock;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask

  // Starts the command and counts the cycles for which the sequencer reports busy.
  task automatic run(output logic [31:0] n);
    wr(4'h5, 32'h1);
    #1;
    n = 0;
    while (o_busy === 1'b1 && n < 5000) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    rd(4'h8, rv);
    chk(32'(rv[7]), 32'h1);
    wr(4'h8, 32'h80);
    rd(4'h8, rv);
    chk(32'(rv[7]), 32'h0);
  endtask

  task automatic t_reset();
    rd(4'h0, rv);
    chk(rv, 32'h0001_8070);
    rd(4'h2, rv);
    chk(rv, 32'h08);
    rd(4'h1, rv);
    chk(rv, 32'h0);
    rd(4'h5, rv);
    chk(rv, 32'h0);
    rd(4'hf, rv);
    chk(rv, 32'h0);
  endtask

  task automatic t_startup();
    @(posedge i_clock);
    i_startup_read <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    chk(32'(o_macro.enable), 32'h1);
    @(posedge i_clock);
    i_startup_read <= 1'b0;
    repeat (3) @(posedge i_clock);
    #1;
    chk(32'(o_macro.enable), 32'h0);
  endtask

  task automatic t_protect();
    wr(4'h1, 32'h46);
    wr(4'h2, 32'h88);
    wr(4'h5, 32'h1);
    repeat (2) @(posedge i_clock);
    #1;
    chk(32'(o_busy), 32'h0);
  endtask

  task automatic t_stages();
    logic [3:0]  codes [7] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hd};
    logic [3:0]  masks [7] = '{4'h5, 4'h4, 4'h4, 4'hf, 4'hd, 4'h5, 4'h4};
    logic [7:0]  ctl;
    logic [3:0]  m;
    logic [15:0] base;
    logic [31:0] len;
    wr(4'h6, 32'h97);
    wr(4'h0, 32'h0000_c049);
    rd(4'h0, rv);
    chk(rv, 32'h0000_c049);
    wr(4'h3, 32'h2a5);
    wr(4'h4, 32'h1234_5678);
    for (int i = 0; i < 7; i++) begin
      ctl = i[0] ? 8'hd8 : 8'ha8;
      m = masks[i];
      wr(4'h2, {24'h0, ctl});
      wr(4'h1, {24'h0, m, codes[i]});
      base = active;
      run(len);
      chk(len, 32'(m[3]) * 2 + 32'(m[2]) * 4 + 32'(m[1]) * 3 + 32'(m[0]) * 5);
      if (codes[i] == 4'hd) begin
        chk(32'(active), 32'(base));
      end else begin
        chk(32'(op_seen), 32'(codes[i]));
        chk(32'(pulse_len), 32'h4);
        chk(32'(ctl_seen), {27'h0, 1'b1, ctl[6:3]});
        chk(32'(addr_seen), 32'h2a5);
      end
    end
  endtask

  // A set hold field and a hold bit in the mask must not lengthen the assist passes.
  task automatic t_assist();
    logic [31:0] len;
    wr(4'h0, 32'h0001_807c);
    wr(4'h2, 32'h88);
    wr(4'h1, 32'hfe);
    run(len);
    chk(len, 32'd32);
    chk(32'(prog_addr), 32'h2a4);
    chk(prog_data, 32'h1234_5678);
  endtask

  initial begin
    i_clock        = 1'b0;
    i_resetn       = 1'b0;
    i_reg_addr     = 4'h0;
    i_reg_wdata    = 32'h0;
    i_reg_write    = 1'b0;
    i_reg_read     = 1'b0;
    i_startup_read = 1'b0;
    n_fail         = 0;
    checks_done    = 0;
    repeat (6) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_reset();
    t_startup();
    t_protect();
    t_stages();
    t_assist();
    test_done();
  end

  // The whole run needs well under a thousand cycles, so this span only trips on a hang.
  initial begin
    #400_000;
    n_fail++;
    test_done();
  end
endmodule
